// >>> bench/dtb_chk_sva.sv
// Purpose: port assertions for the trace buffer
// Assumes: control bits mirrored from taken APB writes
// Notes: bound into dtb_top
`include "dtb_regs.svh"
module dtb_chk (
	input wire logic        clk_i,
	input wire logic        reset_n_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0]  pstrb_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        cmp_a_hit_i,
	input wire logic        cmp_b_hit_i,
	input wire logic        cmp_in_range_i,
	input wire logic        match0_o,
	input wire logic        match1_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [6:0] c_q;
	logic       tk;
	logic       wr;
	// taken transfer and window read
	assign tk = psel_i && penable_i && !pready_o;
	assign wr = tk && !pwrite_i && (paddr_i & 12'hFFC) == `DTB_WIN_OFS;
	// mirror of the control register
	always_ff @(posedge clk_i) begin
		if (!reset_n_i)
			c_q <= 7'h00;
		else if (tk && pwrite_i && (paddr_i & 12'hFFC) == `DTB_CTRL_OFS && pstrb_i[0])
			c_q <= pwdata_i[6:0];
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	property p_ab;
		reset_n_i && c_q[6:5] == `DTB_MAP_AB |=>
			match0_o == $past(cmp_a_hit_i) && match1_o == $past(cmp_b_hit_i);
	endproperty
	a_ab: assert property (p_ab) else $error("map 00 wrong");
	property p_in;
		reset_n_i && c_q[6:5] == `DTB_MAP_IN |=> match0_o == $past(cmp_in_range_i) && !match1_o;
	endproperty
	a_in: assert property (p_in) else $error("map 01 wrong");
	property p_out;
		reset_n_i && c_q[6:5] == `DTB_MAP_OUT |=> match0_o == !$past(cmp_in_range_i) && !match1_o;
	endproperty
	a_out: assert property (p_out) else $error("map 10 wrong");
	property p_rsv;
		reset_n_i && c_q[6:5] == 2'h3 |=> match0_o == $past(cmp_a_hit_i) && !match1_o;
	endproperty
	a_rsv: assert property (p_rsv) else $error("map 11 wrong");
	property p_arm;
		wr && c_q[`DTB_C_ARM] |=> pready_o && prdata_o == 32'h0;
	endproperty
	a_arm: assert property (p_arm) else $error("armed read not zero");
	property p_mis;
		wr && paddr_i[1:0] != 2'h0 |=> prdata_o == 32'h0;
	endproperty
	a_mis: assert property (p_mis) else $error("misaligned read not zero");
	property p_src;
		wr && !c_q[`DTB_C_TSRC] |=> prdata_o == 32'h0;
	endproperty
	a_src: assert property (p_src) else $error("source off read not zero");
	property p_half;
		wr |=> prdata_o[31:16] == 16'h0;
	endproperty
	a_half: assert property (p_half) else $error("window wider than 16");
endmodule : dtb_chk
bind dtb_top dtb_chk u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .cmp_a_hit_i(cmp_a_hit_i),
	.cmp_b_hit_i(cmp_b_hit_i), .cmp_in_range_i(cmp_in_range_i), .match0_o(match0_o),
	.match1_o(match1_o));

// >>> bench/tb_top.sv
// Purpose: self-checking bench of the trace buffer
// Assumes: APB answer timing as handed over
// Notes: comparator inputs change at random every cycle
`include "dtb_regs.svh"
module tb_top
	import dtb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i, reset_n_i, psel_i, penable_i, pwrite_i, secured_i, pc_valid_i;
	logic        cmp_a_hit_i, cmp_b_hit_i, cmp_in_range_i;
	logic        pready_o, pslverr_o, match0_o, match1_o, err;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic [3:0]  pstrb_i;
	logic [17:0] pc_i;
	integer      seed = 32'hbb04;
	integer      bad_count = 0;
	integer      checked = 0;
	dtb_line_t   q[$];
	dtb_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .secured_i(secured_i),
		.pc_valid_i(pc_valid_i), .pc_i(pc_i), .cmp_a_hit_i(cmp_a_hit_i),
		.cmp_b_hit_i(cmp_b_hit_i), .cmp_in_range_i(cmp_in_range_i), .match0_o(match0_o),
		.match1_o(match1_o));
	// 25 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	// random comparator hits
	always @(posedge clk_i) {cmp_a_hit_i, cmp_b_hit_i, cmp_in_range_i} <= 3'($random(seed));
	task automatic end_sim();
		if (bad_count == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one APB transfer, held until pready
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		// look mid-cycle: the value seen stands at the next rising edge
		do @(negedge clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		@(posedge clk_i);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_i);
	endtask : bus
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdc
	// capture groups of pcs, model the lines, read them back
	task automatic trace(input logic [6:0] c, input int grp);
		logic [17:0] p;
		logic [19:0] l;
		int          n;
		int          s;
		int          e;
		q.delete();
		n = 0;
		s = -1;
		e = -1;
		l = 20'h0;
		p = 18'($random(seed)) | 18'h10000;
		bus(1'b1, 12'h020, 32'(c | 7'h01));
		rdc(12'h024, 32'h0);
		for (int g = 0; g < grp; g++) begin
			p[17:6] += 12'h1;
			for (int k = 0; k <= g; k++) begin
				// loop-once corner: second pc of a group repeats the first
				if (k > 0 && !(c[3] && k == 1)) p[5:0] = 6'($random(seed));
				pc_i <= p;
				pc_valid_i <= 1'b1;
				@(posedge clk_i);
				if (c[3] && !c[2] && k == 1) continue;
				// line after the last slot is forced to a base line
				if (k == 0 || !c[2] || (n == 0 && q.size() == 64)) begin
					if (n > 0) q.push_back(l);
					q.push_back({2'h0, p});
					n = 0;
					l = 20'h0;
				end else begin
					l[6*n +: 6] = p[5:0];
					n++;
					l[19:18] = 2'(n);
					if (n == 3) q.push_back(l);
					if (n == 3) l = 20'h0;
					if (n == 3) n = 0;
				end
			end
		end
		pc_valid_i <= 1'b0;
		if (n > 0) q.push_back(l);
		// end-aligned keeps the newest lines, stop mode the oldest
		while (q.size() > 64) begin
			if (c[4]) void'(q.pop_front());
			else void'(q.pop_back());
		end
		bus(1'b1, 12'h020, 32'(c));
		rdc(12'h024, 32'h0);
		bus(1'b1, 12'h024, 32'h0);
		foreach (q[i]) begin
			if (i == 1) begin
				rdc(12'h026, 32'h0);
				bus(1'b1, 12'h020, 32'(c & 7'h7D));
				rdc(12'h024, 32'h0);
				bus(1'b1, 12'h020, 32'(c));
				secured_i <= 1'b1;
				repeat (3) @(posedge clk_i);
				rdc(12'h024, 32'h0);
				secured_i <= 1'b0;
				repeat (3) @(posedge clk_i);
			end
			rdc(12'h024, {16'h0, q[i][15:0]});
			rdc(12'h024, {28'h0, q[i][19:16]});
			// reader starts at the oldest entry; its first base line must sit where the model's first base line does
			if (s < 0 && rd[3:2] == 2'h0) s = i;
			if (e < 0 && q[i][19:18] == 2'h0) e = i;
		end
		chk(32'(s), 32'(e));
	endtask : trace
	// main sequence
	initial begin
		reset_n_i = 1'b0;
		{psel_i, penable_i, pwrite_i, secured_i, pc_valid_i} = 5'h00;
		{paddr_i, pwdata_i, pc_i} = 62'h0;
		pstrb_i = 4'hF;
		repeat (8) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		rdc(12'h024, 32'h0);
		bus(1'b0, 12'h030, 32'h0);
		chk({31'h0, err}, 32'h1);
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, 12'h020, 32'(m) << 5);
			repeat (20) @(posedge clk_i);
		end
		trace(7'h06, 5);
		reset_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		bus(1'b1, 12'h020, 32'h06);
		bus(1'b1, 12'h024, 32'h0);
		rdc(12'h024, {16'h0, q[0][15:0]});
		trace(7'h02, 3);
		trace(7'h0A, 3);
		trace(7'h06, 18);
		trace(7'h16, 18);
		end_sim();
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		end_sim();
	end
endmodule : tb_top

// >>> design/dtb_match_map.sv
// Purpose: maps comparator hits onto the two match outputs
// Assumes: hit and range inputs come from the same clock domain
// Notes: purely combinational, registered by the caller
`include "dtb_regs.svh"

module dtb_match_map
	import dtb_pkg::*;
(
	input  wire logic [1:0] map_i,
	input  wire logic       a_hit_i,
	input  wire logic       b_hit_i,
	input  wire logic       in_range_i,
	output logic            match0_o,
	output logic            match1_o
);
	// code selects the source of each match
	always_comb begin
		case (map_i)
			`DTB_MAP_AB: begin
				match0_o = a_hit_i;
				match1_o = b_hit_i;
			end
			`DTB_MAP_IN: begin
				match0_o = in_range_i;
				match1_o = 1'b0;
			end
			`DTB_MAP_OUT: begin
				match0_o = ~in_range_i;
				match1_o = 1'b0;
			end
			default: begin
				match0_o = a_hit_i;
				match1_o = 1'b0;
			end
		endcase
	end
endmodule : dtb_match_map

// >>> design/dtb_pkg.sv
// Purpose: types shared by the trace buffer modules
// Assumes: dtb_regs.svh supplies sizes
// Notes: the buffer array sits inside the state struct
`include "dtb_regs.svh"

package dtb_pkg;
	typedef logic [`DTB_LINE_W-1:0] dtb_line_t;

	typedef struct packed {
		logic                          arm;
		logic                          tsrc;
		logic                          pc_only;
		logic                          loop_once_mode;
		logic                          end_al;
		logic [1:0]                    map;
		logic [`DTB_PTR_W-1:0]         wr_ptr;
		logic                          rolled;
		logic                          full;
		logic                          have_base;
		logic [11:0]                   base;
		logic                          have_last;
		logic [17:0]                   last_pc;
		logic                          pend_v;
		dtb_line_t                     pend_line;
		logic [`DTB_PTR_W:0]           rd_ptr;
		logic                          unlocked;
		logic                          sec1;
		logic                          sec2;
		logic [31:0]                   prdata;
		logic                          pready;
		logic                          pslverr;
		logic                          m0;
		logic                          m1;
		logic [`DTB_DEPTH-1:0][`DTB_LINE_W-1:0] mem;
	} dtb_state_s;
endpackage : dtb_pkg

// >>> design/dtb_regs.svh
// Purpose: offsets, field positions, codes and sizes of the trace buffer
// Assumes: APB byte addresses, 32-bit data, one register per aligned word
// Notes: included by the package and by the design modules
//
// Functional notes
// - window returns data only when unlocked, unsecured, disarmed and source enabled
// - aligned word write while disarmed unlocks reading, contents untouched
// - lines are 20 bits, read out as 16 bits then 4 bits over two accesses
// - each valid window read advances the read pointer
// - armed keeps the buffer locked against reading
// - byte or misaligned reads return zero, pointer unchanged
// - reads while armed or source disabled return zero, pointer unchanged
// - contents undefined at power-on, kept over every other reset
// - map 00 A/B separate, 01 inside range, 10 outside range, match1 off
// - map code 11 behaves as comparator A on, comparator B off
// - row code 00 base, 01 one, 10 two, 11 three increments
// - new base line when pc bits 17..6 differ from last base
// - increments are offsets within the aligned 64-address range of the base
// - first line written, also after rollover, is a base line
// - normal and loop-once modes put pc bit 16 in pc-high field bit 0
// - end-aligned rollover may overwrite base; write pointer marks oldest entry
`ifndef DTB_REGS_SVH
`define DTB_REGS_SVH

`define DTB_DEPTH        64
`define DTB_PTR_W        6
`define DTB_LINE_W       20
`define DTB_AW           12

`define DTB_CTRL_OFS     12'h020
`define DTB_WIN_OFS      12'h024
`define DTB_STAT_OFS     12'h028

`define DTB_C_ARM        0
`define DTB_C_TSRC       1
`define DTB_C_PCONLY     2
`define DTB_C_LOOP_ONCE_MODE      3
`define DTB_C_ENDAL      4
`define DTB_C_MAP_LO     5
`define DTB_C_MAP_HI     6

`define DTB_S_RPTR_LO    16
`define DTB_S_ROLLED     8
`define DTB_S_UNLOCKED   9
`define DTB_S_SECURED    10
`define DTB_S_FULL       11

`define DTB_CODE_BASE    2'h0
`define DTB_CODE_INC1    2'h1
`define DTB_CODE_INC2    2'h2
`define DTB_CODE_INC3    2'h3

`define DTB_MAP_AB       2'h0
`define DTB_MAP_IN       2'h1
`define DTB_MAP_OUT      2'h2

`endif

// >>> design/dtb_top.sv
// Purpose: program-flow trace buffer with an APB read window
// Assumes: pc_valid_i and pc_i come from core logic on clk_i
// Notes: the line store has no reset so it survives every reset
`include "dtb_regs.svh"

module dtb_top
	import dtb_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  reset_n_i,
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [`DTB_AW-1:0]    paddr_i,
	input  wire logic [31:0]           pwdata_i,
	input  wire logic [3:0]            pstrb_i,
	output logic [31:0]                prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	input  wire logic                  secured_i,
	input  wire logic                  pc_valid_i,
	input  wire logic [17:0]           pc_i,
	input  wire logic                  cmp_a_hit_i,
	input  wire logic                  cmp_b_hit_i,
	input  wire logic                  cmp_in_range_i,
	output logic                       match0_o,
	output logic                       match1_o
);
	localparam logic [`DTB_PTR_W-1:0] LAST_SLOT = `DTB_PTR_W'(`DTB_DEPTH - 1);

	dtb_state_s q;
	dtb_state_s n;

	logic       mm0;
	logic       mm1;
	logic       acc;
	logic       word_al;
	logic       rd_ok;
	logic       arm_rise;
	logic       arm_fall;
	logic       ev;
	logic       need_base;
	logic       merge;
	logic       wr_en;
	logic       at_last;
	logic [5:0] inc;
	logic [1:0] pcode;
	dtb_line_t  rd_line;
	dtb_line_t  new_line;
	logic [`DTB_DEPTH-1:0][`DTB_LINE_W-1:0] keep_mem;

	// comparator to match selection
	dtb_match_map u_map (
		.map_i      (q.map),
		.a_hit_i    (cmp_a_hit_i),
		.b_hit_i    (cmp_b_hit_i),
		.in_range_i (cmp_in_range_i),
		.match0_o   (mm0),
		.match1_o   (mm1)
	);

	// access qualifiers
	assign acc     = psel_i & penable_i & ~q.pready;
	assign word_al = (paddr_i[1:0] == 2'h0);
	assign rd_ok   = q.unlocked & ~q.sec2 & ~q.arm & q.tsrc;
	assign rd_line = q.mem[q.rd_ptr[`DTB_PTR_W:1]];
	assign pcode   = q.pend_line[19:18];
	assign inc     = pc_i[5:0];

	// next-state of the whole block
	always_comb begin
		n           = q;
		n.sec1      = secured_i;
		n.sec2      = q.sec1;
		n.m0        = mm0;
		n.m1        = mm1;
		n.pready    = 1'b0;
		n.pslverr   = 1'b0;
		n.prdata    = 32'h0000_0000;
		ev          = 1'b0;
		need_base   = 1'b0;
		merge       = 1'b0;
		wr_en       = 1'b0;
		at_last     = 1'b0;
		new_line    = '0;
		keep_mem    = q.mem;

		// bus access, acted on one edge before pready is seen
		if (acc) begin
			n.pready = 1'b1;
			case (paddr_i[`DTB_AW-1:2])
				10'(`DTB_CTRL_OFS >> 2): begin
					if (pwrite_i) begin
						if (pstrb_i[0]) begin
							n.arm     = pwdata_i[`DTB_C_ARM];
							n.tsrc    = pwdata_i[`DTB_C_TSRC];
							n.pc_only = pwdata_i[`DTB_C_PCONLY];
							n.loop_once_mode   = pwdata_i[`DTB_C_LOOP_ONCE_MODE];
							n.end_al  = pwdata_i[`DTB_C_ENDAL];
							n.map     = pwdata_i[`DTB_C_MAP_HI:`DTB_C_MAP_LO];
						end
					end else begin
						n.prdata[`DTB_C_ARM]    = q.arm;
						n.prdata[`DTB_C_TSRC]   = q.tsrc;
						n.prdata[`DTB_C_PCONLY] = q.pc_only;
						n.prdata[`DTB_C_LOOP_ONCE_MODE]  = q.loop_once_mode;
						n.prdata[`DTB_C_ENDAL]  = q.end_al;
						n.prdata[`DTB_C_MAP_HI:`DTB_C_MAP_LO] = q.map;
					end
				end
				10'(`DTB_WIN_OFS >> 2): begin
					if (pwrite_i) begin
						// unlock only, buffer lines untouched
						if (~q.arm & word_al & (pstrb_i[1:0] == 2'h3)) begin
							n.unlocked = 1'b1;
							n.rd_ptr   = q.rolled ? {q.wr_ptr, 1'b0} : '0;
						end
					end else if (rd_ok & word_al) begin
						// low 16 bits first, then the top 4 bits
						if (q.rd_ptr[0] == 1'b0) begin
							n.prdata[15:0] = rd_line[15:0];
						end else begin
							n.prdata[3:0] = rd_line[19:16];
						end
						n.rd_ptr = q.rd_ptr + 1'b1;
					end
					// otherwise zero data and pointer held
				end
				10'(`DTB_STAT_OFS >> 2): begin
					if (~pwrite_i) begin
						n.prdata[`DTB_PTR_W-1:0] = q.wr_ptr;
						n.prdata[`DTB_S_ROLLED]   = q.rolled;
						n.prdata[`DTB_S_UNLOCKED] = q.unlocked;
						n.prdata[`DTB_S_SECURED]  = q.sec2;
						n.prdata[`DTB_S_FULL]     = q.full;
						n.prdata[`DTB_S_RPTR_LO +: `DTB_PTR_W + 1] = q.rd_ptr;
					end
				end
				default: begin
					n.pslverr = 1'b1;
				end
			endcase
		end

		arm_rise = n.arm & ~q.arm;
		arm_fall = ~n.arm & q.arm;

		// capture side
		if (arm_rise) begin
			// fresh run, reading locked again
			n.unlocked  = 1'b0;
			n.wr_ptr    = '0;
			n.rolled    = 1'b0;
			n.full      = 1'b0;
			n.have_base = 1'b0;
			n.have_last = 1'b0;
			n.pend_v    = 1'b0;
		end else if (arm_fall) begin
			// a partly filled line is flushed on disarm
			wr_en = q.pend_v & ~q.full;
			n.pend_v = 1'b0;
		end else if (q.arm & q.tsrc & pc_valid_i & ~q.full) begin
			ev = ~(q.loop_once_mode & ~q.pc_only & q.have_last & (pc_i == q.last_pc));
		end

		if (ev) begin
			n.have_last = 1'b1;
			n.last_pc   = pc_i;
			if (q.pc_only) begin
				need_base = ~q.have_base | (pc_i[17:6] != q.base);
				merge = q.pend_v & ~need_base & (pcode != `DTB_CODE_BASE)
					& (pcode != `DTB_CODE_INC3);
			end
			if (merge) begin
				// add the increment into the pending line
				if (pcode == `DTB_CODE_INC1) begin
					n.pend_line = {`DTB_CODE_INC2, 6'h00, inc, q.pend_line[5:0]};
				end else begin
					n.pend_line = {`DTB_CODE_INC3, inc, q.pend_line[11:0]};
				end
			end else begin
				wr_en   = q.pend_v;
				at_last = q.pend_v & (q.wr_ptr == LAST_SLOT);
				if (~q.pc_only) begin
					// pc bits 17:16 land in the pc-high field
					new_line = {2'h0, pc_i};
				end else if (need_base | at_last) begin
					new_line    = {`DTB_CODE_BASE, pc_i};
					n.have_base = 1'b1;
					n.base      = pc_i[17:6];
				end else begin
					new_line = {`DTB_CODE_INC1, 12'h000, inc};
				end
				n.pend_line = new_line;
				n.pend_v    = ~(at_last & ~q.end_al);
			end
		end

		// commit the pending line to the store
		if (wr_en) begin
			n.mem[q.wr_ptr] = q.pend_line;
			n.wr_ptr = q.wr_ptr + 1'b1;
			if (q.wr_ptr == LAST_SLOT) begin
				n.rolled = 1'b1;
				n.full   = ~q.end_al;
			end
		end

		// synchronous reset spares the line store
		if (!reset_n_i) begin
			n          = '0;
			n.mem      = keep_mem;
			n.last_pc  = 18'h00000;
		end
	end

	// single state register
	always_ff @(posedge clk_i) begin
		q <= n;
	end

	// outputs straight from flops
	assign prdata_o  = q.prdata;
	assign pready_o  = q.pready;
	assign pslverr_o = q.pslverr;
	assign match0_o  = q.m0;
	assign match1_o  = q.m1;
endmodule : dtb_top
